//--- core/amb_mux_bist.sv
// adc input multiplexer control, digital self-test stream and post gain
`timescale 1ns/10ps
module amb_mux_bist
	import amb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        low_power,
	input  wire logic [2:0]  pmu_vt_code,
	input  wire logic [2:0]  pmu_cur_code,
	input  wire logic        mod_sample_strobe,
	input  wire logic        mod_bit_current,
	input  wire logic        mod_bit_voltage,
	input  wire logic        filt_result_valid,
	input  wire logic [23:0] filt_result_in,
	input  wire logic [31:0] current_accum_in,
	output logic      [7:0]  vt_mux_onehot,
	output logic             vt_mux_hiz,
	output logic      [7:0]  cur_mux_onehot,
	output logic             dec_bit_current,
	output logic             dec_bit_voltage,
	output logic             raw_filter_capture_enable,
	output logic             serial_if_test_enable,
	output logic             accum_threshold_hit,
	output logic      [23:0] current_result_reg
);
	localparam logic [11:0] ADDR_MUX_SELECT = reg_byte_addr(OFF_MUX_SELECT);
	localparam logic [11:0] ADDR_DIAG       = reg_byte_addr(OFF_DIAG);
	localparam logic [11:0] ADDR_THRESHOLD  = reg_byte_addr(OFF_THRESHOLD);
	localparam logic [11:0] ADDR_POST_GAIN  = reg_byte_addr(OFF_POST_GAIN);
	localparam logic [11:0] ADDR_CONV_MODE  = reg_byte_addr(OFF_CONV_MODE);
	localparam logic [11:0] ADDR_STATUS     = reg_byte_addr(OFF_STATUS);
	localparam int          PM_BITS         = 7;

	// software visible registers
	logic [7:0]         input_mux_select_reg;
	logic [7:0]         mux_next;
	logic [7:0]         diag_enable_reg;
	logic [7:0]         diag_next;
	logic [31:0]        current_accum_threshold_reg;
	logic [31:0]        thr_next;
	logic [1:0]         post_gain_reg;
	logic [1:0]         gain_next;
	logic [2:0]         converter_mode_field;
	logic [2:0]         mode_next;

	// power manager word: three stages, then taken once stages two and three agree
	logic [PM_BITS-1:0] pm_s1_reg;
	logic [PM_BITS-1:0] pm_s1_next;
	logic [PM_BITS-1:0] pm_s2_reg;
	logic [PM_BITS-1:0] pm_s2_next;
	logic [PM_BITS-1:0] pm_s3_reg;
	logic [PM_BITS-1:0] pm_s3_next;
	logic [PM_BITS-1:0] pm_word_reg;
	logic [PM_BITS-1:0] pm_word_next;
	logic               low_power_sync;
	logic [2:0]         pmu_vt_sync;
	logic [2:0]         pmu_cur_sync;

	// multiplexer steering
	logic [7:0]         vt_next;
	logic [7:0]         cur_next;
	logic               hiz_next;
	logic [2:0]         vt_code;
	logic [2:0]         cur_code;
	logic               manual_sel;

	// self-test stream, threshold compare and result
	logic               dec_i_next;
	logic               dec_v_next;
	logic               stream_bit;
	logic               rotate_en;
	logic               thr_write;
	logic               hit_next;
	logic [23:0]        result_next;
	logic               wr_en;
	logic               acc_en;
	logic               selftest_enable;

	function automatic logic [7:0] code_onehot(input logic [2:0] code);
		code_onehot = 8'h01 << code;
	endfunction

	function automatic logic [23:0] gain_sat(input logic [23:0] v, input logic [1:0] g);
		logic [24:0] d;
		d = {v[23], v} <<< 1;
		if (g == GAIN_ONE) begin
			gain_sat = v;
		end else if (d[24] != d[23]) begin
			gain_sat = d[24] ? NEG_FULL : POS_FULL;
		end else begin
			gain_sat = d[23:0];
		end
	endfunction

	function automatic logic addr_known_f(input logic [11:0] a);
		case (a)
			ADDR_MUX_SELECT, ADDR_DIAG, ADDR_THRESHOLD:  addr_known_f = 1'b1;
			ADDR_POST_GAIN, ADDR_CONV_MODE, ADDR_STATUS: addr_known_f = 1'b1;
			default:                                     addr_known_f = 1'b0;
		endcase
	endfunction

	assign pready          = 1'b1;
	assign acc_en          = psel & penable;
	assign wr_en           = acc_en & pwrite;
	assign thr_write       = wr_en & (paddr == ADDR_THRESHOLD);
	assign selftest_enable = diag_enable_reg[DIAG_SELFTEST];
	assign raw_filter_capture_enable = diag_enable_reg[DIAG_RAW];
	assign serial_if_test_enable     = diag_enable_reg[DIAG_SIF];
	assign rotate_en       = selftest_enable & mod_sample_strobe;

	// read data and error response
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = acc_en & !addr_known_f(paddr);
		case (paddr)
			ADDR_MUX_SELECT: begin
				prdata = {24'h000000, input_mux_select_reg};
			end
			ADDR_DIAG: begin
				prdata = {24'h000000, diag_enable_reg};
			end
			ADDR_THRESHOLD: begin
				prdata = current_accum_threshold_reg;
			end
			ADDR_POST_GAIN: begin
				prdata = {30'h00000000, post_gain_reg};
			end
			ADDR_CONV_MODE: begin
				prdata = {29'h00000000, converter_mode_field};
			end
			ADDR_STATUS: begin
				prdata = {31'h00000000, selftest_enable};
			end
			default: begin
				prdata = 32'h0000_0000;
			end
		endcase
	end

	// power manager word synchroniser
	always_comb begin
		pm_s1_next   = {low_power, pmu_vt_code, pmu_cur_code};
		pm_s2_next   = pm_s1_reg;
		pm_s3_next   = pm_s2_reg;
		pm_word_next = (pm_s2_reg == pm_s3_reg) ? pm_s3_reg : pm_word_reg;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pm_s1_reg   <= 7'h00;
			pm_s2_reg   <= 7'h00;
			pm_s3_reg   <= 7'h00;
			pm_word_reg <= 7'h00;
		end else begin
			pm_s1_reg   <= pm_s1_next;
			pm_s2_reg   <= pm_s2_next;
			pm_s3_reg   <= pm_s3_next;
			pm_word_reg <= pm_word_next;
		end
	end

	assign low_power_sync = pm_word_reg[6];
	assign pmu_vt_sync    = pm_word_reg[5:3];
	assign pmu_cur_sync   = pm_word_reg[2:0];

	// register writes; a write to the threshold wins over a rotation
	always_comb begin
		mux_next  = input_mux_select_reg;
		diag_next = diag_enable_reg;
		thr_next  = current_accum_threshold_reg;
		gain_next = post_gain_reg;
		mode_next = converter_mode_field;
		if (rotate_en && !thr_write) begin
			thr_next = {current_accum_threshold_reg[31:PAT_BITS],
				current_accum_threshold_reg[0],
				current_accum_threshold_reg[PAT_BITS-1:1]};
		end
		if (wr_en) begin
			case (paddr)
				ADDR_MUX_SELECT: begin
					mux_next = pwdata[7:0];
				end
				ADDR_DIAG: begin
					diag_next = pwdata[7:0];
				end
				ADDR_THRESHOLD: begin
					thr_next = pwdata;
				end
				ADDR_POST_GAIN: begin
					gain_next = pwdata[1:0];
				end
				ADDR_CONV_MODE: begin
					mode_next = pwdata[2:0];
				end
				default: begin
					mux_next = input_mux_select_reg;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			input_mux_select_reg        <= RST_MUX_SELECT;
			diag_enable_reg             <= RST_DIAG;
			current_accum_threshold_reg <= RST_THRESHOLD;
			post_gain_reg               <= RST_POST_GAIN;
			converter_mode_field        <= RST_CONV_MODE;
		end else begin
			input_mux_select_reg        <= mux_next;
			diag_enable_reg             <= diag_next;
			current_accum_threshold_reg <= thr_next;
			post_gain_reg               <= gain_next;
			converter_mode_field        <= mode_next;
		end
	end

	// multiplexer source selection
	always_comb begin
		manual_sel = (converter_mode_field == MODE_MANUAL) && !low_power_sync;
		if (low_power_sync) begin
			vt_code  = pmu_vt_sync;
			cur_code = pmu_cur_sync;
		end else if (manual_sel) begin
			vt_code  = input_mux_select_reg[VT_LSB +: 3];
			cur_code = input_mux_select_reg[CUR_LSB +: 3];
		end else begin
			vt_code  = converter_mode_field;
			cur_code = converter_mode_field;
		end
		hiz_next = (vt_code == 3'h7);
		vt_next  = hiz_next ? 8'h00 : code_onehot(vt_code);
		cur_next = code_onehot(cur_code);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vt_mux_onehot  <= 8'h00;
			vt_mux_hiz     <= 1'b0;
			cur_mux_onehot <= 8'h00;
		end else begin
			vt_mux_onehot  <= vt_next;
			vt_mux_hiz     <= hiz_next;
			cur_mux_onehot <= cur_next;
		end
	end

	// decimation filter inputs
	always_comb begin
		stream_bit = current_accum_threshold_reg[0];
		dec_i_next = selftest_enable ? stream_bit : mod_bit_current;
		dec_v_next = selftest_enable ? stream_bit : mod_bit_voltage;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dec_bit_current <= 1'b0;
			dec_bit_voltage <= 1'b0;
		end else begin
			dec_bit_current <= dec_i_next;
			dec_bit_voltage <= dec_v_next;
		end
	end

	// threshold compare, masked while the threshold holds a pattern
	always_comb begin
		hit_next = !selftest_enable && (current_accum_in >= current_accum_threshold_reg);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			accum_threshold_hit <= 1'b0;
		end else begin
			accum_threshold_hit <= hit_next;
		end
	end

	// post gain with saturation
	always_comb begin
		if (filt_result_valid) begin
			result_next = gain_sat(filt_result_in, post_gain_reg);
		end else begin
			result_next = current_result_reg;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			current_result_reg <= 24'h000000;
		end else begin
			current_result_reg <= result_next;
		end
	end
endmodule

//--- core/amb_pkg.sv
// constants and address helper for the adc mux select and self-test block
// Contract
// - vt source code steers mux in mode seven while low power is off
// - vt codes decode to seven source pairs, code seven to hi-z
// - bits five to three select current sources
// - self-test active only while enable bit set
// - one stream feeds both decimation filters
// - low 30 threshold bits rotate as pattern
// - lowest pattern bit is the stream bit
// - threshold compare unavailable during self-test
// - post gain one or two, saturating
// - other modes ignore mux select register
// - diag bits: selftest, raw capture, serial test
package amb_pkg;
	localparam logic [11:0] OFF_MUX_SELECT = 12'h0d0;
	localparam logic [11:0] OFF_DIAG       = 12'h0d1;
	localparam logic [11:0] OFF_THRESHOLD  = 12'h0d4;
	localparam logic [11:0] OFF_POST_GAIN  = 12'h0d8;
	localparam logic [11:0] OFF_CONV_MODE  = 12'h0dc;
	localparam logic [11:0] OFF_STATUS     = 12'h0e0;
	localparam logic [7:0]  RST_MUX_SELECT = 8'h00;
	localparam logic [7:0]  RST_DIAG       = 8'h80;
	localparam logic [31:0] RST_THRESHOLD  = 32'h0000_0000;
	localparam logic [1:0]  RST_POST_GAIN  = 2'h0;
	localparam logic [2:0]  RST_CONV_MODE  = 3'h0;
	localparam logic [2:0]  MODE_MANUAL    = 3'h7;
	localparam int          VT_LSB         = 0;
	localparam int          CUR_LSB        = 3;
	localparam int          DIAG_SELFTEST  = 0;
	localparam int          DIAG_RAW       = 1;
	localparam int          DIAG_SIF       = 2;
	localparam int          PAT_BITS       = 30;
	localparam int          RES_BITS       = 24;
	localparam logic [1:0]  GAIN_ONE       = 2'h0;
	localparam logic [1:0]  GAIN_TWO       = 2'h1;
	localparam logic [23:0] POS_FULL       = 24'h7fffff;
	localparam logic [23:0] NEG_FULL       = 24'h800000;

	// offsets above are register indices; each register is one aligned word
	function automatic logic [11:0] reg_byte_addr(input logic [11:0] idx);
		reg_byte_addr = {idx[9:0], 2'b00};
	endfunction
endpackage

//--- testbench/amb_modulator.sv
// modulator model: random stream bits toward the block
`timescale 1ns/10ps
module amb_modulator (
	input  wire logic clk,
	output logic      bit_current = 1'b0,
	output logic      bit_voltage = 1'b1
);
	always @(posedge clk) begin
		bit_current <= 1'($urandom);
		bit_voltage <= 1'($urandom);
	end
endmodule

//--- testbench/amb_checker.sv
// concurrent checks on the mux select and self-test ports
`timescale 1ns/10ps
module amb_checker
	import amb_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        mod_bit_current,
	input wire logic        filt_result_valid,
	input wire logic [7:0]  vt_mux_onehot,
	input wire logic        vt_mux_hiz,
	input wire logic [7:0]  cur_mux_onehot,
	input wire logic        dec_bit_current,
	input wire logic        dec_bit_voltage,
	input wire logic        raw_filter_capture_enable,
	input wire logic        accum_threshold_hit,
	input wire logic [23:0] current_result_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic st_reg;
	logic st_next;
	logic wr;
	assign wr = psel && penable && pwrite && paddr == reg_byte_addr(OFF_DIAG);
	always_comb st_next = wr ? pwdata[DIAG_SELFTEST] : st_reg;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) st_reg <= 1'b0;
		else st_reg <= st_next;
	a_hiz_empty: assert property (vt_mux_hiz |-> vt_mux_onehot == 8'h00) else $error("hiz");
	a_vt_onehot: assert property ($past(arst_n) && !vt_mux_hiz |-> $onehot(vt_mux_onehot))
		else $error("vt mux");
	a_cur_onehot: assert property ($past(arst_n) |-> $onehot(cur_mux_onehot))
		else $error("cur mux");
	a_raw_follow: assert property (wr |-> ##2 raw_filter_capture_enable == $past(pwdata[1], 2))
		else $error("raw bit");
	a_same_stream: assert property (st_reg && $past(st_reg, 2) |-> dec_bit_current == dec_bit_voltage)
		else $error("streams");
	a_hit_masked: assert property (st_reg && $past(st_reg, 2) |-> !accum_threshold_hit)
		else $error("hit");
	a_norm_path: assert property ($past(arst_n) && !st_reg && !$past(st_reg, 2)
		|-> dec_bit_current == $past(mod_bit_current)) else $error("normal path");
	a_result_hold: assert property ($past(arst_n) && !$past(filt_result_valid)
		|-> $stable(current_result_reg)) else $error("result");
endmodule
bind amb_mux_bist amb_checker chk_i (.*);

//--- testbench/amb_mux_bist_tb.sv
// self-checking bench for the mux select and self-test block
`timescale 1ns/10ps
module amb_mux_bist_tb import amb_pkg::*;;
	logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, low_power = 0, err;
	logic        mod_sample_strobe = 0, filt_result_valid = 0, pready, pslverr, vt_mux_hiz;
	logic        mod_bit_current, mod_bit_voltage, dec_bit_current, dec_bit_voltage;
	logic        raw_filter_capture_enable, serial_if_test_enable, accum_threshold_hit;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, current_accum_in = 0, prdata, rd;
	logic [2:0]  pmu_vt_code = 0, pmu_cur_code = 0, c;
	logic [23:0] filt_result_in = 0, x, current_result_reg;
	logic [7:0]  vt_mux_onehot, cur_mux_onehot;
	logic [29:0] p;
	logic [1:0]  m;
	int          checked = 0, n_mismatch = 0;
	always #10 clk = ~clk;
	amb_modulator mdl (.clk(clk), .bit_current(mod_bit_current), .bit_voltage(mod_bit_voltage));
	amb_mux_bist uut (.*);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= reg_byte_addr(a);
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	function automatic logic [23:0] gain2(input logic [23:0] v);
		if (v[23] != v[22]) return v[23] ? NEG_FULL : POS_FULL;
		return {v[22:0], 1'b0};
	endfunction
	task automatic summarize;
		if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		void'($urandom(53));
		repeat (16) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		apb(0, OFF_MUX_SELECT, 0);
		chk(rd, RST_MUX_SELECT);
		apb(0, OFF_DIAG, 0);
		chk(rd, RST_DIAG);
		apb(0, 12'h0fc, 1);
		chk(rd, 0);
		chk(err, 1);
		apb(1, OFF_CONV_MODE, MODE_MANUAL);
		for (int i = 0; i < 8; i++) begin
			c = 3'($urandom);
			apb(1, OFF_MUX_SELECT, 32'({c, i[2:0]}));
			settle();
			chk({vt_mux_hiz, vt_mux_onehot}, i == 7 ? 9'h100 : 1 << i);
			chk(cur_mux_onehot, 1 << c);
		end
		apb(1, OFF_CONV_MODE, 3);
		settle();
		chk({vt_mux_onehot, cur_mux_onehot}, 16'h0808);
		low_power <= 1;
		pmu_vt_code <= 3'($urandom);
		pmu_cur_code <= 3'($urandom);
		repeat (6) settle();
		chk(vt_mux_onehot | cur_mux_onehot,
			(pmu_vt_code == 3'h7 ? 0 : 1 << pmu_vt_code) | (1 << pmu_cur_code));
		low_power <= 0;
		for (int g = 0; g < 4; g++) begin
			apb(1, OFF_POST_GAIN, g);
			for (int j = 0; j < 5; j++) begin
				x = j == 0 ? 24'h400000 : j == 1 ? 24'hbfffff : j == 2 ? 24'hc00000 : 24'($urandom);
				filt_result_valid <= 1;
				filt_result_in <= x;
				@(posedge clk);
				filt_result_valid <= 0;
				settle();
				chk(current_result_reg, g ? gain2(x) : x);
			end
		end
		p = 30'($urandom);
		current_accum_in <= '1;
		apb(1, OFF_THRESHOLD, {2'b11, p});
		apb(1, OFF_DIAG, 1);
		for (int i = 0; i < 34; i++) begin
			mod_sample_strobe <= 1;
			@(posedge clk);
			mod_sample_strobe <= 0;
			p = {p[0], p[29:1]};
			settle();
			chk({accum_threshold_hit, dec_bit_voltage, dec_bit_current}, {1'b0, p[0], p[0]});
		end
		apb(1, OFF_DIAG, 6);
		settle();
		chk({serial_if_test_enable, raw_filter_capture_enable}, 2'b11);
		repeat (4) begin
			@(posedge clk);
			m = {mod_bit_voltage, mod_bit_current};
			#1;
			chk({accum_threshold_hit, dec_bit_voltage, dec_bit_current}, {1'b1, m});
		end
		summarize();
	end
endmodule
